/* logic/dpl_sequencer.sv */
// top of the power mode, link enable and calibration sequencer
// assumes host logic on clk_sys_in drives the control ports, the pcm
// bit clock arrives on link_clk_in and line pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module dpl_sequencer #(
    parameter int unsigned PLL_LOCK_CYCLES   = dpl_pkg::PLL_LOCK_CYC,
    parameter int unsigned RCAL_CYCLES       = dpl_pkg::RCAL_CYC,
    parameter int unsigned ADC_CAL_CYCLES    = dpl_pkg::ADC_CAL_CYC,
    parameter int unsigned LINK_SETUP_CYCLES = dpl_pkg::LINK_SETUP_CYC
) (
    // clocks and reset
    input  wire logic       clk_sys_in,
    input  wire logic       link_clk_in,
    input  wire logic       arst_n_in,
    // power control image
    input  wire logic       pd_write_in,
    input  wire logic [7:0] pd_data_in,
    // calibration control
    input  wire logic       resistor_cal_disable_in,
    input  wire logic       auto_cal_disable_in,
    input  wire logic       manual_cal_trigger_in,
    // line handling request
    input  wire logic       offhook_req_in,
    // pins from the pcm and line side
    input  wire logic       frame_sync_in,
    input  wire logic       line_ack_in,
    input  wire logic       ring_in,
    input  wire logic       dc_stable_in,
    input  wire logic       line_power_in,
    // power state
    output logic [3:0]      power_mode_out,
    output logic            link_powerdown_out,
    output logic            device_powerdown_out,
    output logic            core_active_out,
    // link state
    output logic            pll_locked_out,
    output logic            frame_detect_flag_out,
    output logic            link_timeout_out,
    output logic            init_ready_out,
    // line state
    output logic            offhook_out,
    output logic            ring_detect_n_out,
    // calibration state
    output logic            rcal_busy_out,
    output logic            adc_cal_busy_out,
    output logic            cal_done_out
);
    dpl_core_if core ();

    dpl_pkg::dpl_mode_e mode;
    logic [2:0]         pin_meta;
    logic [2:0]         pin_sync;
    logic [1:0]         lk_meta;
    logic [1:0]         lk_sync;
    logic               link_enable;
    logic               power_prev;
    logic               manual_cal_trigger_prev;
    logic               cal_start;
    logic               manual_start;
    logic [31:0]        setup_cnt;
    logic               pd_written;
    logic               ring_sync;
    logic               dc_stable_sync;
    logic               power_sync;
    logic               locked_sync;
    logic               fdt_sync;

    // two control bits select the power mode
    function automatic dpl_pkg::dpl_mode_e decode_mode(
        input logic lpd,
        input logic dpd
    );
        dpl_pkg::dpl_mode_e m;
        m = dpl_pkg::DPL_MODE_RESET;
        unique case ({lpd, dpd})
            2'h0: m = dpl_pkg::DPL_MODE_NORMAL;
            2'h1: m = dpl_pkg::DPL_MODE_SLEEP;
            2'h2: m = dpl_pkg::DPL_MODE_RESET;
            2'h3: m = dpl_pkg::DPL_MODE_FULLPD;
        endcase
        return m;
    endfunction

    // mode follows the bits alone
    assign mode = decode_mode(link_powerdown_out,
                              device_powerdown_out);

    // line pins: two flops before anything reads them
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {ring_in, dc_stable_in, line_power_in};
            pin_sync <= pin_meta;
        end
    end
    assign ring_sync      = pin_sync[2];
    assign dc_stable_sync = pin_sync[1];
    assign power_sync     = pin_sync[0];

    // lock and link-up levels cross from the link clock
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lk_meta <= 2'h0;
            lk_sync <= 2'h0;
        end else begin
            lk_meta <= {core.pll_locked, core.established};
            lk_sync <= lk_meta;
        end
    end
    assign locked_sync = lk_sync[1];
    assign fdt_sync    = lk_sync[0];

    // powerdown bits; sleep and full powerdown are left only by reset,
    // so writes there are dropped rather than half-waking the core
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_powerdown_out   <= dpl_pkg::LINK_PD_RST;
            device_powerdown_out <= dpl_pkg::DEV_PD_RST;
            pd_written           <= 1'h0;
        end else if (pd_write_in && (mode == dpl_pkg::DPL_MODE_RESET
                     || mode == dpl_pkg::DPL_MODE_NORMAL)) begin
            link_powerdown_out   <= pd_data_in[dpl_pkg::PD_LINK_BIT];
            device_powerdown_out <= pd_data_in[dpl_pkg::PD_DEV_BIT];
            pd_written           <= 1'h1;
        end
    end

    // link runs in normal and sleep only
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in)
            link_enable <= 1'h0;
        else
            link_enable <= !link_powerdown_out;
    end
    assign core.link_enable = link_enable;

    // power state outputs
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            power_mode_out  <= dpl_pkg::DPL_MODE_RESET;
            core_active_out <= 1'h1;
        end else begin
            power_mode_out  <= mode;
            core_active_out <= (mode == dpl_pkg::DPL_MODE_RESET
                || mode == dpl_pkg::DPL_MODE_NORMAL);
        end
    end

    // link status; line-side state counts only with frame detect
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pll_locked_out        <= 1'h0;
            frame_detect_flag_out <= 1'h0;
            init_ready_out        <= 1'h0;
        end else begin
            pll_locked_out        <= locked_sync;
            frame_detect_flag_out <= fdt_sync && link_enable;
            init_ready_out        <= fdt_sync
                && mode == dpl_pkg::DPL_MODE_NORMAL;
        end
    end

    // link setup watchdog, cleared whenever the link is off
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            setup_cnt        <= 32'h0;
            link_timeout_out <= 1'h0;
        end else if (!link_enable || fdt_sync) begin
            setup_cnt        <= 32'h0;
            link_timeout_out <= 1'h0;
        end else if (setup_cnt != 32'(LINK_SETUP_CYCLES)) begin
            setup_cnt <= setup_cnt + 32'h1;
            if (setup_cnt + 32'h1 == 32'(LINK_SETUP_CYCLES))
                link_timeout_out <= 1'h1;
        end
    end

    // off-hook only in normal mode with the link up; never by default
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in)
            offhook_out <= 1'h0;
        else
            offhook_out <= offhook_req_in && fdt_sync
                && mode == dpl_pkg::DPL_MODE_NORMAL;
    end

    // ring indication, active low, dead in reset mode and full powerdown
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in)
            ring_detect_n_out <= 1'h1;
        else
            ring_detect_n_out <= !(ring_sync && fdt_sync
                && (mode == dpl_pkg::DPL_MODE_NORMAL
                || mode == dpl_pkg::DPL_MODE_SLEEP));
    end

    // calibration triggers: off-hook edge, loss of line power while
    // off-hook, manual bit falling after being set
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            power_prev   <= 1'h0;
            manual_cal_trigger_prev    <= 1'h0;
            cal_start    <= 1'h0;
            manual_start <= 1'h0;
        end else begin
            power_prev   <= power_sync;
            manual_cal_trigger_prev    <= manual_cal_trigger_in;
            cal_start    <= (offhook_req_in && fdt_sync && !offhook_out
                && mode == dpl_pkg::DPL_MODE_NORMAL)
                || (offhook_out && power_prev && !power_sync);
            manual_start <= manual_cal_trigger_prev && !manual_cal_trigger_in
                && mode == dpl_pkg::DPL_MODE_NORMAL;
        end
    end
    assign core.cal_start_auto   = cal_start;
    assign core.manual_start     = manual_start;
    assign core.rcal_disable     = resistor_cal_disable_in;
    assign core.auto_cal_disable = auto_cal_disable_in;
    assign core.dc_stable        = dc_stable_sync;

    // calibration outputs, registered
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rcal_busy_out    <= 1'h0;
            adc_cal_busy_out <= 1'h0;
            cal_done_out     <= 1'h0;
        end else begin
            rcal_busy_out    <= core.rcal_busy;
            adc_cal_busy_out <= core.adc_busy;
            cal_done_out     <= core.cal_done;
        end
    end

    dpl_link_end #(
        .LOCK_CYCLES (PLL_LOCK_CYCLES)
    ) u_link (
        .link_clk_in   (link_clk_in),
        .arst_n_in     (arst_n_in),
        .frame_sync_in (frame_sync_in),
        .line_ack_in   (line_ack_in),
        .lnk           (core.link_end)
    );

    dpl_cal_engine #(
        .RCAL_CYCLES (RCAL_CYCLES),
        .ADC_CYCLES  (ADC_CAL_CYCLES)
    ) u_cal (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .cal        (core.cal_end)
    );

    AST_RESET_DEFAULTS: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        !pd_written |-> link_powerdown_out && !device_powerdown_out
            && !offhook_out && !frame_detect_flag_out)
        else $error("reset defaults not held before first write");
    AST_OFFHOOK_NORMAL: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        offhook_out |-> $past(mode == dpl_pkg::DPL_MODE_NORMAL)
            && $past(fdt_sync))
        else $error("off-hook outside normal mode");
    AST_FULLPD_NO_RING: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        mode == dpl_pkg::DPL_MODE_FULLPD |=> ring_detect_n_out
            && !core_active_out)
        else $error("ring detect active in full powerdown");
    AST_SLEEP_HOLDS: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        mode == dpl_pkg::DPL_MODE_SLEEP |=> mode == dpl_pkg::DPL_MODE_SLEEP
            && link_enable)
        else $error("sleep left without reset or link dropped");
    AST_LINK_GATED: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        link_powerdown_out |=> !link_enable ##1 !frame_detect_flag_out)
        else $error("link active while link powerdown set");
    AST_TIMEOUT_LIMIT: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        $rose(link_timeout_out) |-> $past(setup_cnt)
            == 32'(LINK_SETUP_CYCLES) - 32'h1)
        else $error("link timeout at the wrong count");
    AST_CAL_ON_OFFHOOK: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        cal_start && !resistor_cal_disable_in && !rcal_busy_out
            && !adc_cal_busy_out && !core.rcal_busy && !core.adc_busy
            && !(u_cal.state == dpl_pkg::DPL_CAL_SETTLE)
        |-> ##[1:2] rcal_busy_out)
        else $error("off-hook did not start resistor calibration");
endmodule
`default_nettype wire

/* pkg/dpl_pkg.sv */
// constants and types of the power, link and calibration sequencer
// assumes a 4 ns system clock and a 64 ns pcm bit clock
package dpl_pkg;
    // clock periods
    localparam int unsigned SYS_CLK_PERIOD_NS  = 4;
    localparam int unsigned LINK_CLK_PERIOD_NS = 64;
    // pll lock is a longest time on the link clock: round down
    localparam int unsigned PLL_LOCK_TIME_MS = 1;
    localparam int unsigned PLL_LOCK_CYC =
        (PLL_LOCK_TIME_MS * 1000000) / LINK_CLK_PERIOD_NS;
    // calibration lengths are least times: round up
    localparam int unsigned RCAL_TIME_MS = 17;
    localparam int unsigned RCAL_CYC =
        (RCAL_TIME_MS * 1000000 + SYS_CLK_PERIOD_NS - 1)
        / SYS_CLK_PERIOD_NS;
    localparam int unsigned ADC_CAL_TIME_MS = 256;
    localparam int unsigned ADC_CAL_CYC =
        (ADC_CAL_TIME_MS * 1000000 + SYS_CLK_PERIOD_NS - 1)
        / SYS_CLK_PERIOD_NS;
    // link setup limit is a longest time: round down
    localparam int unsigned LINK_SETUP_TIME_MS = 10;
    localparam int unsigned LINK_SETUP_CYC =
        (LINK_SETUP_TIME_MS * 1000000) / SYS_CLK_PERIOD_NS;
    // frames seen with a line answer before the link counts as up
    localparam logic [2:0] FRAME_CONFIRM = 3'h4;
    // power control image: bit positions and reset values
    localparam int unsigned PD_LINK_BIT = 4;
    localparam int unsigned PD_DEV_BIT  = 3;
    localparam logic LINK_PD_RST = 1'h1;
    localparam logic DEV_PD_RST  = 1'h0;
    // power modes
    typedef enum logic [3:0] {
        DPL_MODE_RESET  = 4'h1,
        DPL_MODE_NORMAL = 4'h2,
        DPL_MODE_SLEEP  = 4'h4,
        DPL_MODE_FULLPD = 4'h8
    } dpl_mode_e;
    // calibration states
    typedef enum logic [3:0] {
        DPL_CAL_IDLE   = 4'h1,
        DPL_CAL_RES    = 4'h2,
        DPL_CAL_SETTLE = 4'h4,
        DPL_CAL_ADC    = 4'h8
    } dpl_cal_e;
endpackage

/* pkg/dpl_core_if.sv */
// signals between the sequencer top, its link end and its calibrator
// assumes the top drives the ctrl side on clk_sys_in
`timescale 1ns/1ps
`default_nettype none
interface dpl_core_if;
    logic link_enable;      // system domain level
    logic pll_locked;       // link domain level
    logic established;      // link domain level
    logic cal_start_auto;   // one-cycle pulse
    logic manual_start;     // one-cycle pulse
    logic rcal_disable;
    logic auto_cal_disable;
    logic dc_stable;
    logic rcal_busy;
    logic adc_busy;
    logic cal_done;
    modport link_end (input link_enable, output pll_locked, established);
    modport cal_end (input cal_start_auto, manual_start, rcal_disable,
                     auto_cal_disable, dc_stable,
                     output rcal_busy, adc_busy, cal_done);
endinterface
`default_nettype wire

/* logic/dpl_link_end.sv */
// link end: pll lock and frame detection on the pcm bit clock
// assumes link_clk_in runs free, as the pcm clock must in sleep
`timescale 1ns/1ps
`default_nettype none
module dpl_link_end #(
    parameter int unsigned LOCK_CYCLES = dpl_pkg::PLL_LOCK_CYC
) (
    // clock and reset
    input  wire logic link_clk_in,
    input  wire logic arst_n_in,
    // pins on the pcm side
    input  wire logic frame_sync_in,
    input  wire logic line_ack_in,
    // core signals
    dpl_core_if.link_end lnk
);
    logic [2:0]  in_meta;
    logic [2:0]  in_sync;
    logic        fs_prev;
    logic [31:0] lock_cnt;
    logic [2:0]  frames;
    logic        fs_rise;

    // enable, frame sync and line answer: two flops each
    always_ff @(posedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            in_meta <= 3'h0;
            in_sync <= 3'h0;
            fs_prev <= 1'h0;
        end else begin
            in_meta <= {lnk.link_enable, frame_sync_in, line_ack_in};
            in_sync <= in_meta;
            fs_prev <= in_sync[1];
        end
    end
    assign fs_rise = in_sync[1] && !fs_prev;

    // pll lock counts bit clocks from reset release
    always_ff @(posedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lock_cnt       <= 32'h0;
            lnk.pll_locked <= 1'h0;
        end else if (!lnk.pll_locked) begin
            lock_cnt <= lock_cnt + 32'h1;
            if (lock_cnt + 32'h1 >= 32'(LOCK_CYCLES))
                lnk.pll_locked <= 1'h1;
        end
    end

    // link up after a few answered frames; drops with enable or answer
    always_ff @(posedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frames          <= 3'h0;
            lnk.established <= 1'h0;
        end else if (!in_sync[2] || !in_sync[0] || !lnk.pll_locked) begin
            frames          <= 3'h0;
            lnk.established <= 1'h0;
        end else if (fs_rise && frames != dpl_pkg::FRAME_CONFIRM) begin
            frames <= frames + 3'h1;
            if (frames + 3'h1 == dpl_pkg::FRAME_CONFIRM)
                lnk.established <= 1'h1;
        end
    end

    AST_FDT_NEEDS_LINK: assert property (@(posedge link_clk_in)
        disable iff (!arst_n_in)
        lnk.established |-> $past(in_sync[2]) && lnk.pll_locked)
        else $error("frame detect without an enabled, locked link");
endmodule
`default_nettype wire

/* logic/dpl_cal_engine.sv */
// calibrator: resistor calibration, dc settle wait, adc calibration
// assumes single-cycle start pulses on clk_sys_in
`timescale 1ns/1ps
`default_nettype none
module dpl_cal_engine #(
    parameter int unsigned RCAL_CYCLES = dpl_pkg::RCAL_CYC,
    parameter int unsigned ADC_CYCLES  = dpl_pkg::ADC_CAL_CYC
) (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic arst_n_in,
    // core signals
    dpl_core_if.cal_end cal
);
    dpl_pkg::dpl_cal_e state;
    logic [31:0]       cnt;

    // state walk; reset clears any calibration in flight
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state        <= dpl_pkg::DPL_CAL_IDLE;
            cnt          <= 32'h0;
            cal.cal_done <= 1'h0;
        end else begin
            cal.cal_done <= 1'h0;
            unique case (state)
                dpl_pkg::DPL_CAL_IDLE: begin
                    if (cal.cal_start_auto && !cal.rcal_disable) begin
                        state <= dpl_pkg::DPL_CAL_RES;
                        cnt   <= 32'(RCAL_CYCLES);
                    end else if (cal.cal_start_auto
                                 && !cal.auto_cal_disable) begin
                        state <= dpl_pkg::DPL_CAL_SETTLE;
                    end else if (cal.manual_start) begin
                        state <= dpl_pkg::DPL_CAL_ADC;
                        cnt   <= 32'(ADC_CYCLES);
                    end
                end
                dpl_pkg::DPL_CAL_RES: begin
                    cnt <= cnt - 32'h1;
                    if (cnt == 32'h1) begin
                        // adc auto pass is suppressed when disabled
                        state <= cal.auto_cal_disable
                               ? dpl_pkg::DPL_CAL_IDLE
                               : dpl_pkg::DPL_CAL_SETTLE;
                        cal.cal_done <= cal.auto_cal_disable;
                    end
                end
                dpl_pkg::DPL_CAL_SETTLE: begin
                    if (cal.dc_stable) begin
                        state <= dpl_pkg::DPL_CAL_ADC;
                        cnt   <= 32'(ADC_CYCLES);
                    end
                end
                dpl_pkg::DPL_CAL_ADC: begin
                    cnt <= cnt - 32'h1;
                    if (cnt == 32'h1) begin
                        state        <= dpl_pkg::DPL_CAL_IDLE;
                        cal.cal_done <= 1'h1;
                    end
                end
                default: state <= dpl_pkg::DPL_CAL_IDLE;
            endcase
        end
    end
    assign cal.rcal_busy = (state == dpl_pkg::DPL_CAL_RES);
    assign cal.adc_busy  = (state == dpl_pkg::DPL_CAL_ADC);

    sequence s_res_end;
        state == dpl_pkg::DPL_CAL_RES && cnt == 32'h1;
    endsequence

    AST_ADC_AFTER_RES: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        s_res_end ##1 (state == dpl_pkg::DPL_CAL_SETTLE && !cal.dc_stable)
        |=> !cal.adc_busy)
        else $error("adc calibration started before dc settled");
    AST_AUTO_CAL_DISABLE_SKIPS: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        s_res_end and cal.auto_cal_disable |=> state == dpl_pkg::DPL_CAL_IDLE)
        else $error("auto adc calibration ran while disabled");
    AST_MANUAL_IGNORED: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        (state == dpl_pkg::DPL_CAL_RES && cnt != 32'h1 && cal.manual_start)
        |=> state == dpl_pkg::DPL_CAL_RES)
        else $error("manual calibration broke into auto calibration");
    AST_ADC_HOLDS: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        (cal.adc_busy && cnt > 32'h1) |=> cal.adc_busy && !cal.cal_done)
        else $error("adc calibration ended early");
endmodule
`default_nettype wire

/* bench/dpl_pcm_host.sv */
// pcm host model: frame sync every 4 bit clocks, line side answer on demand
// assumes the bench supplies the bit clock and the reset
`timescale 1ns/1ps
`default_nettype none
module dpl_pcm_host (
    // clock and reset
    input  wire logic link_clk_in,
    input  wire logic arst_n_in,
    // bench control: low silences the line side
    input  wire logic answer_in,
    // pcm and line pins
    output logic      frame_sync_out,
    output logic      line_ack_out
);
    logic [1:0] cnt;
    // sync never pauses, sleep included, so the bit clock stays live
    always_ff @(posedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            cnt <= 2'h0;
        else
            cnt <= cnt + 2'h1;
    end
    assign frame_sync_out = (cnt == 2'h3);
    assign line_ack_out   = answer_in;
endmodule
`default_nettype wire

/* bench/daa_power_link_calibration_test.sv */
// self-checking bench of the power, link and calibration sequencer
// assumes the shortened counts set on the dut instance below
`timescale 1ns/1ps
`default_nettype none
module daa_power_link_calibration_test;
    logic clk_sys_in = 0, link_clk_in = 0, arst_n_in = 0, pdw = 0;
    logic rcd = 0, acd = 0, man = 0, ohr = 0, ring = 0, dcs = 0, lpw = 1;
    logic [7:0] pdd = 8'h10;
    logic ans = 1; // line side answers unless a test silences it
    logic [3:0] mode, mq[$];
    logic fs, ack, lpd, dpd, core, lock, frame_detect_flag, tmo, rdy, off, rgn, rb, ab, done;
    int mismatches = 0, total_checks = 0;
    initial forever #2 clk_sys_in = ~clk_sys_in;
    initial begin #13; forever #32 link_clk_in = ~link_clk_in; end
    dpl_pcm_host host (.link_clk_in(link_clk_in), .arst_n_in(arst_n_in),
        .frame_sync_out(fs), .line_ack_out(ack), .answer_in(ans));
    dpl_sequencer #(.PLL_LOCK_CYCLES(8), .RCAL_CYCLES(20),
        .ADC_CAL_CYCLES(40), .LINK_SETUP_CYCLES(600)) dut (
        .clk_sys_in(clk_sys_in), .link_clk_in(link_clk_in),
        .arst_n_in(arst_n_in), .pd_write_in(pdw), .pd_data_in(pdd),
        .resistor_cal_disable_in(rcd), .auto_cal_disable_in(acd),
        .manual_cal_trigger_in(man), .offhook_req_in(ohr),
        .frame_sync_in(fs), .line_ack_in(ack), .ring_in(ring),
        .dc_stable_in(dcs), .line_power_in(lpw), .power_mode_out(mode),
        .link_powerdown_out(lpd), .device_powerdown_out(dpd),
        .core_active_out(core), .pll_locked_out(lock),
        .frame_detect_flag_out(frame_detect_flag), .link_timeout_out(tmo),
        .init_ready_out(rdy), .offhook_out(off), .ring_detect_n_out(rgn),
        .rcal_busy_out(rb), .adc_cal_busy_out(ab), .cal_done_out(done));
    task automatic check(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) begin
            mismatches++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // bounded wait on a level or one-cycle pulse, sampled at falling edges
    task automatic wait_for(ref logic s, input int n, input string m);
        repeat (n) if (s !== 1'b1) @(negedge clk_sys_in);
        check(s, m);
    endtask
    // write the power image; the expected mode goes to the queue first
    task automatic pd(input logic [1:0] b, input logic [3:0] e);
        if (e !== 4'h0) mq.push_back(e);
        @(negedge clk_sys_in);
        pdd = {3'($urandom), b, 3'($urandom)};
        pdw = 1;
        tick(1);
        pdw = 0;
    endtask
    // long hold so the link domain also sees reset edges
    task automatic rst();
        if (mode !== 4'h1 && arst_n_in) mq.push_back(4'h1);
        arst_n_in = 0;
        tick(40);
        check(mode === 4'h1 && lpd && !dpd && rgn && !off, "reset");
        arst_n_in = 1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // mode watcher: every change must match the oldest queued note
    initial begin
        @(posedge arst_n_in);
        forever begin
            @(mode);
            #1;
            check(mq.size() > 0 && mq.pop_front() === mode, "mode");
        end
    end
    initial begin
        #100us;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(6889));
        rst();
        repeat (40) @(negedge link_clk_in); // lock before link enable
        check(lock, "pll lock");
        pd(2'b10, 4'h0);
        ohr = 1;
        tick(100);
        check(!frame_detect_flag && !off && !tmo, "link held off");
        pd(2'b00, 4'h2);
        wait_for(frame_detect_flag, 600, "frame detect");
        tick(2);
        check(rdy && !tmo && core, "ready");
        wait_for(off, 10, "offhook");
        wait_for(rb, 10, "rcal");
        man = 1;
        tick(1);
        man = 0; // toggle in resistor cal must be ignored
        tick(25);
        check(!rb && !ab, "dc settle wait");
        dcs = 1;
        wait_for(ab, 10, "auto adc");
        man = 1;
        tick(1);
        man = 0;
        wait_for(done, 50, "auto done");
        tick(6);
        check(!ab && !rb, "manual ignored");
        {rcd, acd, lpw} = 3'h6;
        tick(30);
        check(!ab && !rb, "auto suppressed");
        man = 1;
        tick(1);
        man = 0;
        tick(35);
        check(ab, "manual running");
        wait_for(done, 12, "manual done");
        {rcd, acd, lpw} = 3'h3;
        tick(6);
        lpw = 0;
        wait_for(rb, 10, "rcal on power loss");
        wait_for(done, 30, "rcal only done");
        check(!ab, "no auto adc");
        pd(2'b01, 4'h4);
        pd(2'b00, 4'h0); // refused in sleep
        ring = 1;
        tick(4);
        check(dpd && !core, "sleep locked");
        check(!rgn, "ring in sleep");
        rst();
        ring = 1;
        pd(2'b11, 4'h8);
        tick(30);
        check(rgn && !core, "full powerdown");
        rst();
        ans = 0;
        wait_for(lock, 200, "relock");
        pd(2'b00, 4'h2);
        tick(595);
        check(!tmo && !frame_detect_flag, "no answer");
        wait_for(tmo, 10, "link timeout");
        ans = 1;
        wait_for(frame_detect_flag, 600, "late link");
        tick(2);
        check(!tmo, "timeout cleared");
        tally_and_finish();
    end
endmodule
`default_nettype wire
